/* File: pfi_chk.sv */
// Port-level assertions for the fault interrupt block
`timescale 1ns/1ps
module pfi_chk
    import pfi_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        ce,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        buck1_overcurrent,
    input wire logic        buck2_overcurrent,
    input wire logic        buck3_overcurrent,
    input wire logic        fuse_error_present,
    input wire logic        fuse_blow_running,
    input wire logic        boost_overcurrent,
    input wire logic [5:0]  linear_overcurrent,
    input wire logic        irq_out_n
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [2:0] bk, mb;
    logic       tk, rd, wr, wrote_reg;
    // Taken transfers; live inputs grouped as the sense bytes show them
    assign tk = hsel && hready && htrans == HTRANS_NONSEQ && ce;
    assign rd = tk && !hwrite;
    assign wr = tk && hwrite;
    assign bk = {buck3_overcurrent, buck2_overcurrent, buck1_overcurrent};
    assign mb = {fuse_error_present, fuse_blow_running, boost_overcurrent};
    // Until the first write every mask still holds its all-masked reset value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) wrote_reg <= 1'b0;
        else if (wr) wrote_reg <= 1'b1;
    end
    property p_buck_live;
        $stable(bk)[*4] ##0 (rd && haddr[9:2] == ADDR_BUCK_LIVE) ##1 $stable(bk)
            |-> hrdata == {27'h0, bk[2], bk[1], 1'b0, bk[0], bk[0]};
    endproperty
    a_buck_live: assert property (p_buck_live) else $error("buck sense bad");
    property p_mb_live;
        $stable(mb)[*4] ##0 (rd && haddr[9:2] == ADDR_MB_LIVE) ##1 $stable(mb)
            |-> hrdata == {24'h0, mb[2], mb[1], 5'h0, mb[0]};
    endproperty
    a_mb_live: assert property (p_mb_live) else $error("boost sense bad");
    property p_ldo_live;
        $stable(linear_overcurrent)[*4] ##0 (rd && haddr[9:2] == ADDR_LDO_LIVE)
            ##1 $stable(linear_overcurrent) |-> hrdata == {26'h0, linear_overcurrent};
    endproperty
    a_ldo_live: assert property (p_ldo_live) else $error("linear sense bad");
    property p_mb_mask;
        rd && haddr[9:2] == ADDR_MB_MASKS |=> (hrdata & ~{24'h0, MB_BITS}) == 32'h0;
    endproperty
    a_mb_mask: assert property (p_mb_mask) else $error("mask bits bad");
    property p_ldo_mask;
        rd && haddr[9:2] == ADDR_LDO_MASKS |=> (hrdata & ~{24'h0, LDO_BITS}) == 32'h0;
    endproperty
    a_ldo_mask: assert property (p_ldo_mask) else $error("mask bits bad");
    property p_idle;
        !rd |=> hrdata == 32'h0;
    endproperty
    a_idle: assert property (p_idle) else $error("read data outside read");
    property p_masked;
        !wrote_reg |-> irq_out_n;
    endproperty
    a_masked: assert property (p_masked) else $error("irq while masked");
    property p_rise;
        $rose(irq_out_n) |-> $past(wr) || $past(wr, 2) || $past(wr, 3);
    endproperty
    a_rise: assert property (p_rise) else $error("irq released unasked");
endmodule

/* File: pfi_fault_irq.sv */
// Top of the fault interrupt block: AHB-Lite registers, sticky flags, masks, live sense
`timescale 1ns/1ps
module pfi_fault_irq
    import pfi_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        buck1_overcurrent,
    input  wire logic        buck2_overcurrent,
    input  wire logic        buck3_overcurrent,
    input  wire logic        fuse_error_present,
    input  wire logic        fuse_blow_running,
    input  wire logic        boost_overcurrent,
    input  wire logic [5:0]  linear_overcurrent,
    output logic             irq_out_n
);
    import pfi_pkg::*;

    // Synchronised copies of every condition
    logic [SYNC_W-1:0] raw_in;
    logic [SYNC_W-1:0] sync_in;
    logic              buck1_s;
    logic              buck2_s;
    logic              buck3_s;
    logic              fuse_err_s;
    logic              fuse_run_s;
    logic              boost_s;
    logic [5:0]        linear_s;
    logic              fuse_run_d_reg;
    logic              fuse_err_d_reg;

    // Registers
    logic [DW-1:0] mb_flags_reg;
    logic [DW-1:0] mb_flags_next;
    logic [DW-1:0] mb_masks_reg;
    logic [DW-1:0] ldo_flags_reg;
    logic [DW-1:0] ldo_flags_next;
    logic [DW-1:0] ldo_masks_reg;
    logic [DW-1:0] buck_live;
    logic [DW-1:0] mb_live;
    logic [DW-1:0] ldo_live;
    logic [DW-1:0] mb_set;
    logic [DW-1:0] ldo_set;

    // Bus data phase state
    logic                 wr_pend_reg;
    logic                 rd_pend_reg;
    logic [ADDR_BITS-1:0] addr_reg;
    logic                 take;
    logic [DW-1:0]        wdat;
    logic [DW-1:0]        rd_val;

    // Register decode shared by read and write paths
    function automatic logic hit(input logic [ADDR_BITS-1:0] a, input logic [ADDR_BITS-1:0] r);
        return a == r;
    endfunction

    assign raw_in = {linear_overcurrent, boost_overcurrent, fuse_blow_running,
                     fuse_error_present, buck3_overcurrent, buck2_overcurrent,
                     buck1_overcurrent};

    pfi_sync u_sync (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .ce       (ce),
        .async_in (raw_in[SYNC_W-1:0]),
        .sync_out (sync_in)
    );

    // Unpack synchronised inputs
    assign buck1_s    = sync_in[0];
    assign buck2_s    = sync_in[1];
    assign buck3_s    = sync_in[2];
    assign fuse_err_s = sync_in[3];
    assign fuse_run_s = sync_in[4];
    assign boost_s    = sync_in[5];
    assign linear_s   = sync_in[SYNC_W-1:6];

    // Live sense views; they track inputs from reset on, no stored default
    always_comb begin
        buck_live                = ZERO8;
        buck_live[BIT_BUCK3]     = buck3_s;
        buck_live[BIT_BUCK2]     = buck2_s;
        buck_live[BIT_BUCK1_HI]  = buck1_s;
        buck_live[BIT_BUCK1_LO]  = buck1_s;
        mb_live                  = ZERO8;
        mb_live[BIT_FUSE_ERR]    = fuse_err_s;
        mb_live[BIT_FUSE_BLOW]   = fuse_run_s;
        mb_live[BIT_BOOST]       = boost_s;
        ldo_live                 = {2'b00, linear_s};
    end

    // Edge memory for the one-shot memory events
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fuse_run_d_reg <= 1'b0;
            fuse_err_d_reg <= 1'b0;
        end else if (ce) begin
            fuse_run_d_reg <= fuse_run_s;
            fuse_err_d_reg <= fuse_err_s;
        end
    end

    // Set terms: error on detection, blow-done on falling run, limits as levels
    always_comb begin
        mb_set                = ZERO8;
        mb_set[BIT_FUSE_ERR]  = fuse_err_s & ~fuse_err_d_reg;
        mb_set[BIT_FUSE_BLOW] = fuse_run_d_reg & ~fuse_run_s;
        mb_set[BIT_BOOST]     = boost_s;
        ldo_set               = {2'b00, linear_s};
    end

    // AHB-Lite address phase capture
    assign take = hsel & hready & (htrans == HTRANS_NONSEQ);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg    <= '0;
        end else if (ce) begin
            if (hready) begin
                wr_pend_reg <= take & hwrite;
                rd_pend_reg <= take & ~hwrite;
                addr_reg    <= haddr[ADDR_BITS+1:2]; // Word index, byte lanes dropped
            end
        end
    end

    // Zero-wait-state slave, always OKAY; size other than word still accepted
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign wdat      = hwdata[DW-1:0];

    // Write-one-to-clear with set winning over clear
    always_comb begin
        mb_flags_next  = mb_flags_reg;
        ldo_flags_next = ldo_flags_reg;
        if (wr_pend_reg && hit(addr_reg, ADDR_MB_FLAGS)) begin
            mb_flags_next = mb_flags_reg & ~wdat;
        end
        if (wr_pend_reg && hit(addr_reg, ADDR_LDO_FLAGS)) begin
            ldo_flags_next = ldo_flags_reg & ~wdat;
        end
        mb_flags_next  = (mb_flags_next | mb_set) & MB_BITS;
        ldo_flags_next = (ldo_flags_next | ldo_set) & LDO_BITS;
    end

    // Sticky flag registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mb_flags_reg  <= FLAGS_RESET;
            ldo_flags_reg <= FLAGS_RESET;
        end else if (ce) begin
            mb_flags_reg  <= mb_flags_next;
            ldo_flags_reg <= ldo_flags_next;
        end
    end

    // Mask registers, reset masked so nothing fires before software is ready
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mb_masks_reg  <= MB_MASK_RESET;
            ldo_masks_reg <= LDO_MASK_RESET;
        end else if (ce && wr_pend_reg) begin
            if (hit(addr_reg, ADDR_MB_MASKS)) begin
                mb_masks_reg <= wdat & MB_BITS;
            end
            if (hit(addr_reg, ADDR_LDO_MASKS)) begin
                ldo_masks_reg <= wdat & LDO_BITS;
            end
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        rd_val = ZERO8;
        if (hit(addr_reg, ADDR_BUCK_LIVE)) begin
            rd_val = buck_live & BUCK_BITS;
        end else if (hit(addr_reg, ADDR_MB_FLAGS)) begin
            rd_val = mb_flags_reg;
        end else if (hit(addr_reg, ADDR_MB_MASKS)) begin
            rd_val = mb_masks_reg;
        end else if (hit(addr_reg, ADDR_MB_LIVE)) begin
            rd_val = mb_live & MB_BITS;
        end else if (hit(addr_reg, ADDR_LDO_FLAGS)) begin
            rd_val = ldo_flags_reg;
        end else if (hit(addr_reg, ADDR_LDO_MASKS)) begin
            rd_val = ldo_masks_reg;
        end else if (hit(addr_reg, ADDR_LDO_LIVE)) begin
            rd_val = ldo_live;
        end
    end

    // Read data is combinational from the data-phase address
    assign hrdata = rd_pend_reg ? {24'h000000, rd_val} : 32'h00000000;

    // Interrupt pin registered to keep it glitch free
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_out_n <= 1'b1;
        end else if (ce) begin
            irq_out_n <= ~(|(mb_flags_reg & ~mb_masks_reg) |
                           |(ldo_flags_reg & ~ldo_masks_reg));
        end
    end
endmodule

/* File: pfi_host.sv */
// Host bus master model: single AHB-Lite word transfers
`timescale 1ns/1ps
module pfi_host
    import pfi_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic      [31:0] haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [31:0] hwdata
);
    initial begin
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
    end
    // Enter just after an edge; no shadow registers are ever touched
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        haddr <= {22'h0, a, 2'b00};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask
endmodule

/* File: pfi_pkg.sv */
// Package with register map, field positions and reset values for the fault interrupt block
package pfi_pkg;
    localparam int         DW = 8;
    // Register indices; 0x13 is printed, the rest are placed around it.
    // Each register takes one aligned word, so the byte address is four times the index.
    localparam logic [7:0] ADDR_BUCK_LIVE = 8'h0C;
    localparam logic [7:0] ADDR_MB_FLAGS  = 8'h0E;
    localparam logic [7:0] ADDR_MB_MASKS  = 8'h0F;
    localparam logic [7:0] ADDR_MB_LIVE   = 8'h10;
    localparam logic [7:0] ADDR_LDO_FLAGS = 8'h11;
    localparam logic [7:0] ADDR_LDO_MASKS = 8'h12;
    localparam logic [7:0] ADDR_LDO_LIVE  = 8'h13;
    localparam int         ADDR_BITS      = 8;
    // Implemented bits per register
    localparam logic [7:0] BUCK_BITS = 8'h1B;
    localparam logic [7:0] MB_BITS   = 8'hC1;
    localparam logic [7:0] LDO_BITS  = 8'h3F;
    // Field positions
    localparam int BIT_BUCK3      = 4;
    localparam int BIT_BUCK2      = 3;
    localparam int BIT_BUCK1_HI   = 1;
    localparam int BIT_BUCK1_LO   = 0;
    localparam int BIT_FUSE_ERR   = 7;
    localparam int BIT_FUSE_BLOW  = 6;
    localparam int BIT_BOOST      = 0;
    localparam int LDO_COUNT      = 6;
    // Reset values: flags clear, masks all masked
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] MB_MASK_RESET  = 8'hC1;
    localparam logic [7:0] LDO_MASK_RESET = 8'h3F;
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;
    localparam int         SYNC_W = 12;
endpackage

/* File: pfi_sync.sv */
// Two-stage synchroniser bank for the fault and sense inputs
`timescale 1ns/1ps
module pfi_sync
    import pfi_pkg::*;
(
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              ce,
    input  wire logic [SYNC_W-1:0] async_in,
    output logic      [SYNC_W-1:0] sync_out
);
    logic [SYNC_W-1:0] meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else if (ce) begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

/* File: tb.sv */
// Self-checking bench for the fault interrupt block
`timescale 1ns/1ps
module tb;
    import pfi_pkg::*;
    logic        hclk, hresetn, hready, irq_n, hresp, hwrite;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [11:0] fin;
    logic [7:0]  xl, xm, ml, mm, w;
    int          mismatches, n_tests;
    pfi_fault_irq DUT (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(HSIZE_WORD), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .buck1_overcurrent(fin[11]),
        .buck2_overcurrent(fin[10]), .buck3_overcurrent(fin[9]), .fuse_error_present(fin[8]),
        .fuse_blow_running(fin[7]), .boost_overcurrent(fin[6]), .linear_overcurrent(fin[5:0]),
        .irq_out_n(irq_n));
    pfi_host u_host (.hclk(hclk), .hready(hready), .hrdata(hrdata), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata));
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        u_host.xfer(1'b0, a, 32'h0, q);
        chk($sformatf("reg %h", a), {24'h0, e}, q);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_host.xfer(1'b1, a, {24'h0, d}, q);
    endtask
    // Expected pin level from the bench's own flag and mask copies
    function automatic logic [31:0] irq_x();
        return {31'h0, ~|((xl & ~ml) | (xm & ~mm))};
    endfunction
    // Apply an input pattern, track the flags it must set, read live state back
    task automatic drive(input logic [11:0] v);
        if (v[8] && !fin[8]) xm[7] = 1'b1;
        if (!v[7] && fin[7]) xm[6] = 1'b1;
        xm[0] = xm[0] | v[6];
        xl = xl | {2'h0, v[5:0]};
        fin <= v;
        repeat (6) @(posedge hclk);
        rd(ADDR_BUCK_LIVE, {3'h0, v[9], v[10], 1'b0, v[11], v[11]});
        rd(ADDR_MB_LIVE, {v[8], v[7], 5'h0, v[6]});
        rd(ADDR_LDO_LIVE, {2'h0, v[5:0]});
        chk("irq", irq_x(), {31'h0, irq_n});
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Whole run is under a thousand cycles; twenty thousand means a hang
    initial begin
        #200000;
        mismatches++;
        give_verdict();
    end
    initial begin
        mismatches = 0;
        n_tests = 0;
        fin = 12'h815;
        hresetn = 1'b0;
        xl = 8'h15;
        xm = 8'h00;
        ml = LDO_MASK_RESET;
        mm = MB_MASK_RESET;
        void'($urandom(4931));
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(ADDR_LDO_LIVE, 8'h15);
        rd(ADDR_MB_MASKS, MB_MASK_RESET);
        rd(ADDR_LDO_MASKS, LDO_MASK_RESET);
        rd(ADDR_LDO_FLAGS, xl);
        wr(ADDR_LDO_LIVE, 8'hFF);
        rd(8'h40, 8'h00);
        drive(12'h83F);
        wr(ADDR_LDO_FLAGS, 8'h3F);
        rd(ADDR_LDO_FLAGS, 8'h3F);
        repeat (12) begin
            drive(12'($urandom));
            drive(12'($urandom));
            drive(12'h000);
            rd(ADDR_LDO_FLAGS, xl);
            rd(ADDR_MB_FLAGS, xm);
            w = 8'($urandom);
            wr(ADDR_LDO_FLAGS, w);
            wr(ADDR_MB_FLAGS, w);
            xl = xl & ~w;
            xm = xm & ~w;
            w = 8'($urandom);
            wr(ADDR_LDO_MASKS, w);
            wr(ADDR_MB_MASKS, w);
            ml = w & LDO_BITS;
            mm = w & MB_BITS;
            rd(ADDR_LDO_FLAGS, xl);
            rd(ADDR_MB_MASKS, mm);
            chk("irq", irq_x(), {31'h0, irq_n});
        end
        give_verdict();
    end
endmodule
bind pfi_fault_irq pfi_chk u_chk (.*);
